// >>> src/kwu_pkg.sv
// constants and types for the key-on wakeup stop release block
// assumes a single 200 MHz ref_clk and an AXI4-Lite register port
package kwu_pkg;

    localparam int unsigned KWU_NKEY      = 4;
    localparam int unsigned KWU_IDX_W     = 12;

    // register indices; byte address is four times the index
    localparam logic [11:0] KWU_IDX_ENABLE = 12'hF9F;
    localparam logic [11:0] KWU_IDX_CTRL   = 12'hFA0;
    localparam logic [11:0] KWU_IDX_STATUS = 12'hFA1;

    // enable register: key 3..0 enables in bits 7..4
    localparam int unsigned KWU_EN_LSB    = 4;
    localparam logic [3:0]  KWU_EN_RST    = 4'h0;

    // control register fields
    localparam int unsigned KWU_CTRL_RELM = 0;
    localparam int unsigned KWU_CTRL_STOP = 1;
    localparam logic        KWU_RELM_RST  = 1'b1;

    // status register fields
    localparam int unsigned KWU_ST_STATE  = 0;
    localparam int unsigned KWU_ST_PORT   = 4;
    localparam int unsigned KWU_ST_PIN    = 8;
    localparam int unsigned KWU_ST_RELM   = 9;

    localparam logic [1:0]  KWU_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  KWU_RESP_SLVERR = 2'h2;
    localparam logic [31:0] KWU_ZERO32      = 32'h0000_0000;

    typedef enum logic [1:0] {
        KWU_RUN,
        KWU_STOP,
        KWU_WARM
    } kwu_state_t;

    // levels on the wake detection path
    typedef struct packed {
        logic       pin;
        logic [3:0] keys;
    } kwu_pins_t;

    // outcome of the release detector
    typedef struct packed {
        logic release_req;
        logic entry_block;
    } kwu_detect_t;

endpackage

// >>> src/kwu_release_detect.sv
// release condition detector for the dedicated pin and four key inputs
// assumes wake path levels are synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module kwu_release_detect (
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire kwu_pkg::kwu_pins_t  pins,
    input  wire logic [3:0]          key_en,
    input  wire logic                relm,
    output kwu_pkg::kwu_detect_t     detect
);

    logic pin_prev;
    logic next_pin_prev;
    logic pin_rise;
    logic key_low;
    logic pin_cond;
    logic key_cond;

    always_comb begin
        next_pin_prev = pins.pin;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_prev <= 1'b0;
        end else begin
            pin_prev <= next_pin_prev;
        end
    end

    always_comb begin
        pin_rise = pins.pin & ~pin_prev;
        key_low  = |(~pins.keys & key_en);
        // level mode: pin high, keys low; edge mode: pin rise only
        pin_cond = relm ? pins.pin : pin_rise;
        key_cond = relm & key_low;
        detect.release_req = pin_cond | key_cond;
        detect.entry_block = pins.pin | key_cond;
    end

endmodule
`default_nettype wire

// >>> src/kwu_wakeup.sv
// key-on wakeup stop release block with AXI4-Lite registers
// assumes ref_clk keeps running while the core sits in stop mode
// and that an outside warm-up counter answers warmup_start
//
// Overview of operation
// - stop mode ends by the dedicated pin or four key inputs.
// - each key input has its own enable bit.
// - enables for keys 3..0 sit in bits 7..4, reset zero.
// - enable bits are write-only; 1 enables, 0 disables.
// - in stop mode with level mode set, a low enabled key input starts release.
// - key pin levels readable through a port register anytime.
// - stop entry with a pending release goes straight to warm-up.
// - wake path and port read path are separate inputs.
// - level mode: pin high, keys low; edge mode: pin rise.
`timescale 1ns/1ps
`default_nettype none
module kwu_wakeup #(
    parameter int unsigned ADDR_W = 16
) (
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire logic [ADDR_W-1:0]   awaddr,
    input  wire logic                awvalid,
    output logic                     awready,
    input  wire logic [31:0]         wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output logic                     wready,
    output logic [1:0]               bresp,
    output logic                     bvalid,
    input  wire logic                bready,
    input  wire logic [ADDR_W-1:0]   araddr,
    input  wire logic                arvalid,
    output logic                     arready,
    output logic [31:0]              rdata,
    output logic [1:0]               rresp,
    output logic                     rvalid,
    input  wire logic                rready,
    input  wire logic                release_pin,
    input  wire logic [3:0]          key_wake_in,
    input  wire logic [3:0]          key_port_in,
    input  wire logic                warmup_done,
    output logic                     stop_mode,
    output logic                     warmup_start
);

    if (ADDR_W < kwu_pkg::KWU_IDX_W + 2) begin : g_bad_addr_w
        $error("ADDR_W too small for the register map");
    end

    // bus state
    logic                aw_full;
    logic                next_aw_full;
    logic                w_full;
    logic                next_w_full;
    logic [ADDR_W-1:0]   aw_addr;
    logic [ADDR_W-1:0]   next_aw_addr;
    logic [31:0]         w_data;
    logic [31:0]         next_w_data;
    logic [3:0]          w_strb;
    logic [3:0]          next_w_strb;
    logic                next_awready;
    logic                next_wready;
    logic                next_bvalid;
    logic [1:0]          next_bresp;
    logic                next_arready;
    logic                next_rvalid;
    logic [31:0]         next_rdata;
    logic [1:0]          next_rresp;

    // register state
    logic [3:0]          key_en;
    logic [3:0]          next_key_en;
    logic                relm;
    logic                next_relm;
    logic                stop_cmd;
    logic                next_stop_cmd;
    logic [3:0]          port_level;
    logic [3:0]          next_port_level;
    logic                pin_level;
    logic                next_pin_level;

    // sequencer state
    kwu_pkg::kwu_state_t state;
    kwu_pkg::kwu_state_t next_state;
    logic                next_stop_mode;
    logic                next_warmup_start;

    kwu_pkg::kwu_pins_t   wake_pins;
    kwu_pkg::kwu_detect_t detect;

    logic                do_write;
    logic [11:0]         w_idx;
    logic [11:0]         r_idx;
    logic                w_hit;
    logic                r_hit;

    assign wake_pins.pin  = release_pin;
    assign wake_pins.keys = key_wake_in;

    kwu_release_detect u_detect (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pins    (wake_pins),
        .key_en  (key_en),
        .relm    (relm),
        .detect  (detect)
    );

    // write channel: address and data taken in either order
    always_comb begin
        w_idx        = aw_addr[kwu_pkg::KWU_IDX_W+1:2];
        w_hit        = (w_idx == kwu_pkg::KWU_IDX_ENABLE) ||
                       (w_idx == kwu_pkg::KWU_IDX_CTRL) ||
                       (w_idx == kwu_pkg::KWU_IDX_STATUS);
        do_write     = aw_full && w_full && !bvalid;
        next_aw_full = aw_full;
        next_w_full  = w_full;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        if (awvalid && awready) begin
            next_aw_full = 1'b1;
            next_aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_w_full = 1'b1;
            next_w_data = wdata;
            next_w_strb = wstrb;
        end
        if (do_write) begin
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = w_hit ? kwu_pkg::KWU_RESP_OKAY
                                 : kwu_pkg::KWU_RESP_SLVERR;
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        next_awready = !next_aw_full && !next_bvalid;
        next_wready  = !next_w_full && !next_bvalid;
    end

    // register writes
    always_comb begin
        next_key_en   = key_en;
        next_relm     = relm;
        next_stop_cmd = 1'b0;
        if (do_write && w_strb[0]) begin
            if (w_idx == kwu_pkg::KWU_IDX_ENABLE) begin
                // one enable bit per key input
                next_key_en = w_data[kwu_pkg::KWU_EN_LSB +: 4];
            end
            if (w_idx == kwu_pkg::KWU_IDX_CTRL) begin
                next_relm     = w_data[kwu_pkg::KWU_CTRL_RELM];
                next_stop_cmd = w_data[kwu_pkg::KWU_CTRL_STOP];
            end
        end
        // port path sampled apart from the wake path
        next_port_level = key_port_in;
        next_pin_level  = release_pin;
    end

    // read channel; enable register reads back as zero
    always_comb begin
        r_idx        = araddr[kwu_pkg::KWU_IDX_W+1:2];
        r_hit        = (r_idx == kwu_pkg::KWU_IDX_ENABLE) ||
                       (r_idx == kwu_pkg::KWU_IDX_CTRL) ||
                       (r_idx == kwu_pkg::KWU_IDX_STATUS);
        next_rvalid  = rvalid;
        next_rdata   = rdata;
        next_rresp   = rresp;
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rdata  = kwu_pkg::KWU_ZERO32;
            next_rresp  = r_hit ? kwu_pkg::KWU_RESP_OKAY
                                : kwu_pkg::KWU_RESP_SLVERR;
            if (r_idx == kwu_pkg::KWU_IDX_CTRL) begin
                next_rdata[kwu_pkg::KWU_CTRL_RELM] = relm;
            end
            if (r_idx == kwu_pkg::KWU_IDX_STATUS) begin
                next_rdata[kwu_pkg::KWU_ST_STATE +: 2] = state;
                next_rdata[kwu_pkg::KWU_ST_PORT +: 4]  = port_level;
                next_rdata[kwu_pkg::KWU_ST_PIN]        = pin_level;
                next_rdata[kwu_pkg::KWU_ST_RELM]       = relm;
            end
        end
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        next_arready = !next_rvalid;
    end

    // stop sequencer
    always_comb begin
        next_state        = state;
        next_stop_mode    = stop_mode;
        next_warmup_start = 1'b0;
        case (state)
            kwu_pkg::KWU_RUN: begin
                if (stop_cmd) begin
                    if (detect.entry_block) begin
                        // pending release: skip stop
                        next_state        = kwu_pkg::KWU_WARM;
                        next_warmup_start = 1'b1;
                    end else begin
                        next_state     = kwu_pkg::KWU_STOP;
                        next_stop_mode = 1'b1;
                    end
                end
            end
            kwu_pkg::KWU_STOP: begin
                if (detect.release_req) begin
                    next_state        = kwu_pkg::KWU_WARM;
                    next_stop_mode    = 1'b0;
                    next_warmup_start = 1'b1;
                end
            end
            kwu_pkg::KWU_WARM: begin
                if (warmup_done) begin
                    next_state = kwu_pkg::KWU_RUN;
                end
            end
            default: begin
                next_state     = kwu_pkg::KWU_RUN;
                next_stop_mode = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            aw_addr <= '0;
            w_data  <= kwu_pkg::KWU_ZERO32;
            w_strb  <= 4'h0;
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= kwu_pkg::KWU_RESP_OKAY;
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= kwu_pkg::KWU_ZERO32;
            rresp   <= kwu_pkg::KWU_RESP_OKAY;
        end else begin
            aw_full <= next_aw_full;
            w_full  <= next_w_full;
            aw_addr <= next_aw_addr;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            awready <= next_awready;
            wready  <= next_wready;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            arready <= next_arready;
            rvalid  <= next_rvalid;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            key_en     <= kwu_pkg::KWU_EN_RST;
            relm       <= kwu_pkg::KWU_RELM_RST;
            stop_cmd   <= 1'b0;
            port_level <= 4'h0;
            pin_level  <= 1'b0;
        end else begin
            key_en     <= next_key_en;
            relm       <= next_relm;
            stop_cmd   <= next_stop_cmd;
            port_level <= next_port_level;
            pin_level  <= next_pin_level;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state        <= kwu_pkg::KWU_RUN;
            stop_mode    <= 1'b0;
            warmup_start <= 1'b0;
        end else begin
            state        <= next_state;
            stop_mode    <= next_stop_mode;
            warmup_start <= next_warmup_start;
        end
    end

endmodule
`default_nettype wire

// >>> tb/kwu_keys.sv
// model of the keys and release switch wired to the wake pins
// assumes the bench drives press, pin_hi and slow at rising edges
`timescale 1ns/1ps
`default_nettype none
module kwu_keys (
    input  wire logic       ref_clk,
    input  wire logic [3:0] press,
    input  wire logic       pin_hi,
    input  wire logic       slow,
    output logic            release_pin,
    output logic [3:0]      key_wake_in,
    output logic [3:0]      key_port_in
);
    logic [4:0] d1 = 5'h0F;
    logic [4:0] d2 = 5'h0F;
    logic [4:0] d3 = 5'h0F;
    logic [4:0] q  = 5'h0F;
    // released keys pulled high, pin low unless asked
    // key pins act as plain digital inputs only
    always @(posedge ref_clk) begin
        d1 <= {pin_hi, ~press};
        d2 <= d1;
        d3 <= d2;
        q <= slow ? d3 : d1;
    end
    assign release_pin = q[4];
    assign key_wake_in = q[3:0];
    assign key_port_in = q[3:0];
endmodule
`default_nettype wire

// >>> tb/kwu_wakeup_chk.sv
// port checker for the key wakeup block
// assumes binding onto kwu_wakeup, one clock domain
`timescale 1ns/1ps
`default_nettype none
module kwu_wakeup_chk #(parameter int unsigned ADDR_W = 16) (
    input wire logic              ref_clk,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic              awvalid,
    input wire logic              awready,
    input wire logic [31:0]       wdata,
    input wire logic              wvalid,
    input wire logic              wready,
    input wire logic [1:0]        bresp,
    input wire logic              bvalid,
    input wire logic              bready,
    input wire logic              arvalid,
    input wire logic              arready,
    input wire logic [31:0]       rdata,
    input wire logic              rvalid,
    input wire logic              rready,
    input wire logic              release_pin,
    input wire logic [3:0]        key_wake_in,
    input wire logic              stop_mode,
    input wire logic              warmup_start
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wu_pulse_a: assert property (warmup_start |=> !warmup_start)
        else $error("warmup_start wider than one cycle");
    stop_exit_a: assert property ($fell(stop_mode) |-> warmup_start)
        else $error("stop left without warm-up start");
    entry_quiet_a: assert property ($rose(stop_mode) |-> !warmup_start)
        else $error("stop entered while warm-up starts");
    pin_rel_a: assert property (stop_mode && release_pin |-> ##[1:3] warmup_start)
        else $error("release pin did not end stop");
    stop_hold_a: assert property (stop_mode && !release_pin && &key_wake_in
        && !$past(release_pin) && &$past(key_wake_in) |=> stop_mode)
        else $error("stop left without a release cause");
    rd_lat_a: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read answer late");
    rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data not held");
    wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response not held");
    wr_lat_a: assert property (awvalid && awready && wvalid && wready
        |-> ##[1:2] bvalid)
        else $error("write response late");
    cover property ($rose(stop_mode));
    cover property (warmup_start && !$past(stop_mode));
    cover property (bvalid && bresp == 2'h2);
endmodule
bind kwu_wakeup kwu_wakeup_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// >>> tb/kwu_wakeup_tb.sv
// self-checking bench for the key wakeup block
// assumes kwu_keys as the far side and the checker bound in
`timescale 1ns/1ps
`default_nettype none
module kwu_wakeup_tb;
    logic        ref_clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, warmup_done;
    logic        release_pin, stop_mode, warmup_start, pin_hi, slow, relm;
    logic [15:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, press, key_wake_in, key_port_in;
    logic [1:0]  bresp, rresp;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          fails, check_count, wu_seen, wu_exp;
    kwu_wakeup dut (.*);
    kwu_keys u_keys (.*);
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic stop_test();
        $display("compares %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("unexpected read at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    task automatic cmp_wr(input logic [1:0] e, input logic [1:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("unexpected resp at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    always @(posedge ref_clk) begin
        if (rvalid && rready)
            cmp_rd(rq.pop_front(), {rresp, rdata});
        if (bvalid && bready)
            cmp_wr(bq.pop_front(), bresp);
        if (warmup_start)
            wu_seen++;
    end
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [11:0] i, input logic [31:0] d,
                      input logic [1:0] e);
        bq.push_back(e);
        awaddr <= {2'h0, i, 2'h0};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] i, input logic [33:0] e);
        rq.push_back(e);
        araddr <= {2'h0, i, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask
    task automatic st_rd(input logic [1:0] s);
        rd(kwu_pkg::KWU_IDX_STATUS, {24'h0, relm, pin_hi, ~press, 2'h0, s});
        cmp_rd({33'h0, s == 2'h1}, {33'h0, stop_mode});
    endtask
    task automatic en_w(input logic [3:0] en);
        wr(kwu_pkg::KWU_IDX_ENABLE, {24'h0, en, 4'($urandom())}, 2'h0);
    endtask
    task automatic warm();
        wu_exp++;
        warmup_done <= 1'b1;
        @(posedge ref_clk);
        warmup_done <= 1'b0;
        idle(2);
        st_rd(2'h0);
    endtask
    task automatic enter(input logic [1:0] s);
        idle(4);
        wr(kwu_pkg::KWU_IDX_CTRL, {30'h0, 1'b1, relm}, 2'h0);
        idle(2);
        st_rd(s);
        if (s == 2'h2)
            warm();
    endtask
    task automatic wake();
        idle(6);
        st_rd(2'h2);
        warm();
    endtask
    initial begin
        #100000;
        fails++;
        stop_test();
    end
    initial begin
        logic [3:0] en;
        {awvalid, wvalid, bready, arvalid, rready, warmup_done} = '0;
        {awaddr, araddr, wdata, press, pin_hi, slow} = '0;
        {fails, check_count, wu_seen, wu_exp} = '0;
        wstrb = 4'hF;
        relm = 1'b1;
        rst = 1'b1;
        void'($urandom(32'h5249));
        idle(4);
        rst <= 1'b0;
        @(posedge ref_clk);
        st_rd(2'h0);
        rd(kwu_pkg::KWU_IDX_ENABLE, 34'h0);
        rd(12'h123, {2'h2, 32'h0});
        wr(12'h123, 32'hFF, 2'h2);
        press <= 4'hF;
        enter(2'h1);
        pin_hi <= 1'b1;
        wake();
        pin_hi <= 1'b0;
        press <= 4'h0;
        for (int k = 0; k < 4; k++) begin
            en = 4'(1 << k) | 4'($urandom());
            slow <= k[0];
            en_w(en);
            enter(2'h1);
            if (en != 4'hF) begin
                press <= ~en;
                idle(6);
                st_rd(2'h1);
            end
            press <= 4'(1 << k);
            wake();
            press <= 4'h0;
        end
        en_w(4'h1);
        press <= 4'h1;
        enter(2'h2);
        press <= 4'h0;
        relm = 1'b0;
        wr(kwu_pkg::KWU_IDX_CTRL, 32'h0, 2'h0);
        en_w(4'hF);
        enter(2'h1);
        press <= 4'hF;
        idle(6);
        st_rd(2'h1);
        press <= 4'h0;
        pin_hi <= 1'b1;
        wake();
        enter(2'h2);
        pin_hi <= 1'b0;
        idle(4);
        cmp_rd(34'(wu_exp), 34'(wu_seen));
        stop_test();
    end
endmodule
`default_nettype wire
